// *** core/sdl_map.svh ***
`ifndef SDL_MAP_SVH
`define SDL_MAP_SVH

// register byte offsets
`define SDL_OFF_CTRL 8'h00
`define SDL_OFF_TXDATA 8'h04
`define SDL_OFF_STATUS 8'h08
`define SDL_OFF_RXDATA 8'h0c

// control field positions
`define SDL_CTRL_ALIGN 0
`define SDL_CTRL_EMPH 1
`define SDL_CTRL_LOOP 2

// status field positions
`define SDL_STAT_LOCK 0
`define SDL_STAT_HUNT 1

// reset values
`define SDL_CTRL_RST 3'h0
`define SDL_TXDATA_RST 18'h00000

// line coding
`define SDL_PAYLOAD_W 18
`define SDL_FRAME_W 20
`define SDL_ALIGN_WORD 18'h1fe00
`define SDL_START_BIT 1'b1
`define SDL_STOP_BIT 1'b0
`define SDL_FRAME_LAST 5'h13

// recovered clock: frame length divided in two halves
`define SDL_RXCLK_LAST 5'h13
`define SDL_RXCLK_HIGH 5'h0a

// good frames in a row before lock
`define SDL_LOCK_WORDS 3'h4

`endif

// *** core/sdl_pkg.sv ***
package sdl_pkg;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } sdl_wb_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } sdl_wb_rsp_t;

   typedef struct packed {
      logic fast_align;
      logic tx_emphasis_select;
      logic internal_loopback_enable;
   } sdl_ctrl_t;

   typedef struct packed {
      logic serial_out_pos;
      logic serial_out_neg;
      logic oe_pos;
      logic oe_neg;
      logic boost;
   } sdl_ser_out_t;

   typedef struct packed {
      logic [17:0] data;
      logic oe;
   } sdl_rx_bus_t;

   typedef enum logic [1:0] {
      SDL_HUNT = 2'b01,
      SDL_LOCKED = 2'b10
   } sdl_lock_state_t;

endpackage : sdl_pkg

// *** core/sdl_rx_align.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "sdl_map.svh"

module sdl_rx_align (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // serial bit stream
   input wire logic bit_i,
   // framed word out
   output logic word_valid_o,
   output logic [17:0] word_o,
   output logic locked_o
);

   logic [19:0] sh_q;
   logic [19:0] sh_d;
   logic [4:0] cnt_q;
   logic [2:0] good_q;
   sdl_pkg::sdl_lock_state_t st_q;
   logic frame_ok;
   logic align_hit;

   assign sh_d = {bit_i, sh_q[19:1]};
   assign frame_ok = (sh_d[0] == `SDL_START_BIT) && (sh_d[19] == `SDL_STOP_BIT);
   assign align_hit = (sh_d == {`SDL_STOP_BIT, `SDL_ALIGN_WORD, `SDL_START_BIT});

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sh_q <= 20'h00000;
      end else begin
         sh_q <= sh_d;
      end
   end

   // sliding search while hunting, fixed boundary while locked; a framed alignment word resets it in either state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= `SDL_FRAME_LAST;
         good_q <= 3'h0;
         st_q <= sdl_pkg::SDL_HUNT;
         word_valid_o <= 1'b0;
         word_o <= 18'h00000;
      end else begin
         word_valid_o <= 1'b0;
         if (align_hit) begin
            cnt_q <= 5'h00;
            good_q <= `SDL_LOCK_WORDS;
            st_q <= sdl_pkg::SDL_LOCKED;
            word_valid_o <= 1'b1;
            word_o <= sh_d[18:1];
         end else if (cnt_q == `SDL_FRAME_LAST) begin
            if (frame_ok) begin
               cnt_q <= 5'h00;
               word_valid_o <= 1'b1;
               word_o <= sh_d[18:1];
               if (good_q != `SDL_LOCK_WORDS) begin
                  good_q <= good_q + 3'h1;
               end
               if (good_q == `SDL_LOCK_WORDS - 3'h1) begin
                  st_q <= sdl_pkg::SDL_LOCKED;
               end
            end else begin
               // stay at the last position: next bit is tried as boundary
               good_q <= 3'h0;
               st_q <= sdl_pkg::SDL_HUNT;
            end
         end else begin
            cnt_q <= cnt_q + 5'h01;
         end
      end
   end

   assign locked_o = (st_q == sdl_pkg::SDL_LOCKED);

   property p_align_boundary;
      @(posedge clk_i) disable iff (rst_i)
      align_hit |=> word_valid_o && locked_o && (cnt_q == 5'h00)
         && (word_o == `SDL_ALIGN_WORD);
   endproperty
   a_align_boundary: assert property (p_align_boundary)
      else $error("alignment word did not set the boundary at once");

endmodule // sdl_rx_align
`default_nettype wire

// *** core/sdl_link_ctrl.sv ***
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "sdl_map.svh"

// Notes on behaviour
// - while fast align is set, transmit the fixed alignment word instead of data.
// - a framed alignment word sets the receive word boundary immediately.
// - with emphasis selected, the first bit of each equal-bit run is boosted.
// - loopback routes the transmitted serial stream into the receiver.
// - during loopback both serial outputs are released to high impedance.
// - lock goes low only after bit sync and start/stop bits are found.
// - recovered clock is serial rate over 20, held low in reset.
// - receive bus valid at recovered clock rise, released during reset.

module sdl_link_ctrl (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register bus
   input wire sdl_pkg::sdl_wb_req_t wb_req_i,
   output sdl_pkg::sdl_wb_rsp_t wb_rsp_o,
   // serial line
   input wire logic serial_in_pos_i,
   output sdl_pkg::sdl_ser_out_t ser_o,
   // parallel receive side
   output sdl_pkg::sdl_rx_bus_t parallel_receive_bus_o,
   output logic rx_clk_o,
   output logic rx_lock_n_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // register bus

   sdl_pkg::sdl_ctrl_t ctrl_q;
   logic [17:0] txdata_q;
   logic ack_q;
   logic [31:0] rdat_q;
   logic [31:0] wmask;
   logic [31:0] wval;
   logic bus_req;
   logic do_write;
   logic [31:0] rdat_d;
   logic rx_locked;
   logic hunting;

   assign bus_req = wb_req_i.cyc && wb_req_i.stb;
   assign do_write = bus_req && wb_req_i.we && !ack_q;

   // byte enables widened to a bit mask
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sel
         assign wmask[gi*8 +: 8] = {8{wb_req_i.sel[gi]}};
      end
   endgenerate

   always_comb begin
      wval = 32'h00000000;
      rdat_d = 32'h00000000;
      unique case (wb_req_i.adr)
         `SDL_OFF_CTRL: begin
            rdat_d[`SDL_CTRL_ALIGN] = ctrl_q.fast_align;
            rdat_d[`SDL_CTRL_EMPH] = ctrl_q.tx_emphasis_select;
            rdat_d[`SDL_CTRL_LOOP] = ctrl_q.internal_loopback_enable;
         end
         `SDL_OFF_TXDATA: begin
            rdat_d[17:0] = txdata_q;
         end
         `SDL_OFF_STATUS: begin
            rdat_d[`SDL_STAT_LOCK] = rx_locked;
            rdat_d[`SDL_STAT_HUNT] = hunting;
         end
         `SDL_OFF_RXDATA: begin
            rdat_d[17:0] = parallel_receive_bus_o.data;
         end
         default: begin
            rdat_d = 32'h00000000;
         end
      endcase
      wval = (rdat_d & ~wmask) | (wb_req_i.dat & wmask);
   end

   // one wait state; unmapped addresses answer with zero and ignore writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h00000000;
      end else begin
         ack_q <= bus_req && !ack_q;
         rdat_q <= (bus_req && !ack_q && !wb_req_i.we) ? rdat_d : 32'h00000000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= `SDL_CTRL_RST;
      end else if (do_write && wb_req_i.adr == `SDL_OFF_CTRL) begin
         ctrl_q.fast_align <= wval[`SDL_CTRL_ALIGN];
         ctrl_q.tx_emphasis_select <= wval[`SDL_CTRL_EMPH];
         ctrl_q.internal_loopback_enable <= wval[`SDL_CTRL_LOOP];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         txdata_q <= `SDL_TXDATA_RST;
      end else if (do_write && wb_req_i.adr == `SDL_OFF_TXDATA) begin
         txdata_q <= wval[17:0];
      end
   end

   assign wb_rsp_o.ack = ack_q;
   assign wb_rsp_o.dat = rdat_q;

   ////////////////////////////////////////////////////////////////////////////////
   // transmitter: one serial bit per clock, start bit first

   logic [4:0] tcnt_q;
   logic [19:0] tsh_q;
   logic tx_bit;
   logic load_frame;
   logic [17:0] tx_payload;

   assign load_frame = (tcnt_q == `SDL_FRAME_LAST);
   assign tx_payload = ctrl_q.fast_align ? `SDL_ALIGN_WORD : txdata_q;
   assign tx_bit = tsh_q[0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tcnt_q <= `SDL_FRAME_LAST;
         tsh_q <= 20'h00000;
      end else if (load_frame) begin
         tcnt_q <= 5'h00;
         tsh_q <= {`SDL_STOP_BIT, tx_payload, `SDL_START_BIT};
      end else begin
         tcnt_q <= tcnt_q + 5'h01;
         tsh_q <= {1'b0, tsh_q[19:1]};
      end
   end

   sdl_pkg::sdl_ser_out_t ser_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ser_q <= '0;
      end else begin
         ser_q.serial_out_pos <= tx_bit;
         ser_q.serial_out_neg <= ~tx_bit;
         ser_q.oe_pos <= !ctrl_q.internal_loopback_enable;
         ser_q.oe_neg <= !ctrl_q.internal_loopback_enable;
         // larger swing on the first bit after a change of level
         ser_q.boost <= ctrl_q.tx_emphasis_select
            && (tx_bit != ser_q.serial_out_pos);
      end
   end

   assign ser_o = ser_q;

   ////////////////////////////////////////////////////////////////////////////////
   // receiver

   logic rx_bit;
   logic wv;
   logic [17:0] rx_word;

   // the loop taps the driven bit even while the pins are released
   assign rx_bit = ctrl_q.internal_loopback_enable
      ? ser_q.serial_out_pos : serial_in_pos_i;

   sdl_rx_align u_align (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .bit_i(rx_bit),
      .word_valid_o(wv),
      .word_o(rx_word),
      .locked_o(rx_locked)
   );

   assign hunting = !rx_locked;

   logic [4:0] rdiv_q;
   logic [4:0] rdiv_d;
   logic rx_clk_q;
   logic lock_n_q;
   sdl_pkg::sdl_rx_bus_t rxbus_q;

   // divider restarts on each word so the rise falls mid-word
   always_comb begin
      if (wv) begin
         rdiv_d = 5'h00;
      end else if (rdiv_q == `SDL_RXCLK_LAST) begin
         rdiv_d = 5'h00;
      end else begin
         rdiv_d = rdiv_q + 5'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdiv_q <= 5'h00;
         rx_clk_q <= 1'b0;
      end else begin
         rdiv_q <= rdiv_d;
         rx_clk_q <= (rdiv_d >= `SDL_RXCLK_HIGH);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rxbus_q <= '0;
      end else begin
         rxbus_q.oe <= 1'b1;
         if (wv && rx_locked) begin
            rxbus_q.data <= rx_word;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_n_q <= 1'b1;
      end else begin
         lock_n_q <= !rx_locked;
      end
   end

   assign parallel_receive_bus_o = rxbus_q;
   assign rx_clk_o = rx_clk_q;
   assign rx_lock_n_o = lock_n_q;

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   property p_align_sent;
      @(posedge clk_i) disable iff (rst_i)
      (load_frame && ctrl_q.fast_align)
         |=> tsh_q == {`SDL_STOP_BIT, `SDL_ALIGN_WORD, `SDL_START_BIT};
   endproperty
   a_align_sent: assert property (p_align_sent)
      else $error("alignment word not loaded while fast align set");

   property p_emph_first_bit;
      @(posedge clk_i) disable iff (rst_i)
      ($past(ctrl_q.tx_emphasis_select) && $changed(ser_q.serial_out_pos)) |-> ser_q.boost;
   endproperty
   a_emph_first_bit: assert property (p_emph_first_bit)
      else $error("first bit of a run not boosted");

   property p_loop_path;
      @(posedge clk_i) disable iff (rst_i)
      (ctrl_q.internal_loopback_enable && $stable(ctrl_q.internal_loopback_enable))
         |-> ##[1:400] !rx_lock_n_o;
   endproperty
   a_loop_path: assert property (p_loop_path)
      else $error("receiver did not lock on looped stream");

   property p_loop_hiz;
      @(posedge clk_i) disable iff (rst_i)
      ctrl_q.internal_loopback_enable |=> !ser_o.oe_pos && !ser_o.oe_neg;
   endproperty
   a_loop_hiz: assert property (p_loop_hiz)
      else $error("serial outputs driven during loopback");

   property p_lock_cause;
      @(posedge clk_i) disable iff (rst_i)
      $fell(rx_lock_n_o) |-> $past(rx_locked) && $past(wv, 1) == 1'b1 || $past(wv, 2);
   endproperty
   a_lock_cause: assert property (p_lock_cause)
      else $error("lock asserted without a framed word");

   // a word that lands off the divider's end restarts the phase; only that cut is excused
   property p_rxclk_shape;
      @(posedge clk_i) disable iff (rst_i || (wv && rdiv_q != `SDL_RXCLK_LAST))
      $rose(rx_clk_o) |-> rx_clk_o[*8] ##1 rx_clk_o ##1 rx_clk_o ##1 !rx_clk_o;
   endproperty
   a_rxclk_shape: assert property (p_rxclk_shape)
      else $error("recovered clock high phase not ten cycles");

   property p_reset_outputs;
      @(posedge clk_i) disable iff (rst_i)
      $fell(rst_i) |-> !rx_clk_o && !parallel_receive_bus_o.oe && rx_lock_n_o;
   endproperty
   a_reset_outputs: assert property (p_reset_outputs)
      else $error("outputs not in reset state at release");

   property p_data_at_rise;
      @(posedge clk_i) disable iff (rst_i)
      $rose(rx_clk_o) |-> $stable(parallel_receive_bus_o.data) && parallel_receive_bus_o.oe;
   endproperty
   a_data_at_rise: assert property (p_data_at_rise)
      else $error("receive data changed at recovered clock rise");

endmodule // sdl_link_ctrl
`default_nettype wire

// *** tb/sdl_far_end.sv ***
`timescale 1ns/1ns
`default_nettype none

// serial line partner: sends framed words, start first, payload lsb first, stop last
module sdl_far_end (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // word source
   input wire logic en_i,
   input wire logic [17:0] word_i,
   // serial line
   output logic bit_o
);
   logic [4:0] pos_q;
   logic [19:0] frame_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pos_q <= 5'h00;
         bit_o <= 1'b0;
         frame_q <= 20'h00000;
      end else if (!en_i) begin
         // line not driven: never shows a steady level
         pos_q <= 5'h00;
         bit_o <= ~bit_o;
      end else begin
         bit_o <= (pos_q == 5'h00) ? 1'b1 : frame_q[pos_q];
         if (pos_q == 5'h00) begin
            frame_q <= {1'b0, word_i, 1'b1};
         end
         pos_q <= (pos_q == 5'h13) ? 5'h00 : pos_q + 5'h01;
      end
   end
endmodule // sdl_far_end

`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "sdl_map.svh"

module tb;
   logic clk_i;
   logic rst_i;
   logic far_en;
   logic far_bit;
   logic [17:0] far_word;
   logic rx_clk;
   logic rx_lock_n;
   logic [31:0] rd;
   sdl_pkg::sdl_wb_req_t wb_req;
   sdl_pkg::sdl_wb_rsp_t wb_rsp;
   sdl_pkg::sdl_ser_out_t ser;
   sdl_pkg::sdl_rx_bus_t rxb;
   int failures;
   int samples_checked;

   sdl_link_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
      .serial_in_pos_i(far_bit), .ser_o(ser), .parallel_receive_bus_o(rxb),
      .rx_clk_o(rx_clk), .rx_lock_n_o(rx_lock_n));
   sdl_far_end far (.clk_i(clk_i), .rst_i(rst_i), .en_i(far_en), .word_i(far_word),
      .bit_o(far_bit));

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task finish_test;
      $display("failures=%0d samples_checked=%0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
      @(posedge clk_i);
      while (wb_rsp.ack !== 1'b1 && n < 50) begin
         n++;
         @(posedge clk_i);
      end
      check(32'(n < 50), 32'h1);
      rd = wb_rsp.dat;
      wb_req <= '0;
   endtask

   task wait_lock(input int lim);
      int n;
      n = 0;
      while (rx_lock_n !== 1'b0 && n < lim) begin
         @(negedge clk_i);
         n++;
      end
      check(32'(n < lim), 32'h1);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task t_regs;
      wb_cycle(1'b0, `SDL_OFF_CTRL, 32'h0);
      check(rd, 32'h0);
      wb_cycle(1'b0, `SDL_OFF_TXDATA, 32'h0);
      check(rd, 32'h0);
      wb_cycle(1'b0, 8'h10, 32'h0);
      check(rd, 32'h0);
      wb_cycle(1'b1, `SDL_OFF_TXDATA, 32'h2a5a5);
   endtask

   task t_tx_frame(input logic align, input logic [17:0] pay);
      logic [39:0] seen;
      logic [19:0] f;
      logic hit;
      wb_cycle(1'b1, `SDL_OFF_CTRL, {31'h0, align});
      repeat (25) @(negedge clk_i);
      for (int i = 0; i < 40; i++) begin
         @(negedge clk_i);
         seen[i] = ser.serial_out_pos;
         check({31'h0, ser.serial_out_neg}, {31'h0, ~ser.serial_out_pos});
      end
      check(ser.oe_pos & ser.oe_neg, 32'h1);
      f = {1'b0, pay, 1'b1};
      hit = 1'b0;
      for (int i = 0; i < 20; i++) begin
         if (seen[i +: 20] === f) hit = 1'b1;
      end
      check(hit, 32'h1);
   endtask

   task t_emphasis;
      logic prev;
      for (int e = 0; e < 2; e++) begin
         wb_cycle(1'b1, `SDL_OFF_CTRL, e[0] ? 32'h2 : 32'h0);
         repeat (25) @(negedge clk_i);
         prev = ser.serial_out_pos;
         for (int i = 0; i < 40; i++) begin
            @(negedge clk_i);
            check(ser.boost, e[0] ? 32'(ser.serial_out_pos !== prev) : 32'h0);
            prev = ser.serial_out_pos;
         end
      end
   endtask

   task t_loopback;
      time t0;
      far_en <= 1'b0;
      wb_cycle(1'b1, `SDL_OFF_CTRL, 32'h5);
      // lock may still stand from the idle line: let one alignment frame come round first
      repeat (45) @(negedge clk_i);
      wait_lock(55);
      check(ser.oe_pos | ser.oe_neg, 32'h0);
      @(posedge rx_clk);
      @(negedge clk_i);
      check(rxb.data, `SDL_ALIGN_WORD);
      check(rxb.oe, 32'h1);
      @(posedge rx_clk);
      t0 = $time;
      @(posedge rx_clk);
      check(32'(($time - t0) / 40), 32'd20);
      wb_cycle(1'b0, `SDL_OFF_STATUS, 32'h0);
      check(rd[0], 32'h1);
      check(rd[1], 32'h0);
   endtask

   task t_ext_rx;
      far_word <= 18'h00fff;
      far_en <= 1'b1;
      wb_cycle(1'b1, `SDL_OFF_CTRL, 32'h0);
      // a lock left over from the loop must first fail and hunt onto the far frames
      repeat (200) @(negedge clk_i);
      wait_lock(1500);
      @(posedge rx_clk);
      @(negedge clk_i);
      check(rxb.data, 32'h00fff);
      far_word <= 18'h0003f;
      repeat (60) @(negedge clk_i);
      @(posedge rx_clk);
      @(negedge clk_i);
      check(rxb.data, 32'h0003f);
      check(rx_lock_n, 32'h0);
      wb_cycle(1'b0, `SDL_OFF_RXDATA, 32'h0);
      check(rd, 32'h0003f);
   endtask

   task t_reset_mid;
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      check(rx_clk, 32'h0);
      check(rxb.oe, 32'h0);
      check(rx_lock_n, 32'h1);
      @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb_cycle(1'b0, `SDL_OFF_CTRL, 32'h0);
      check(rd, 32'h0);
      // too soon after reset for four good frames: still hunting
      wb_cycle(1'b0, `SDL_OFF_STATUS, 32'h0);
      check(rd, 32'h2);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_i = 1'b1;
      far_en = 1'b0;
      far_word = 18'h00000;
      wb_req = '0;
      failures = 0;
      samples_checked = 0;
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      check(rx_clk, 32'h0);
      check(rxb.oe, 32'h0);
      @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs();
      t_tx_frame(1'b1, `SDL_ALIGN_WORD);
      t_tx_frame(1'b0, 18'h2a5a5);
      t_emphasis();
      t_loopback();
      wb_cycle(1'b1, `SDL_OFF_CTRL, 32'h0);
      t_ext_rx();
      t_reset_mid();
      finish_test();
   end

   // hang guard, well above the expected run length
   initial begin
      #(40 * 30000);
      failures++;
      finish_test();
   end
endmodule // tb

`default_nettype wire
